// [dv/tb.sv]
// Purpose: Self-checking bench of the conversion averager
// Assumes: Shortened conversion and standby counts
// Notes: Expected means are rebuilt from the samples sent
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV = 20;
  localparam int STBY = 10;
  logic clock = 0, reset = 1, cfg_wr = 0, rd_en = 0;
  logic [2:0] cfg_sel = 3'h0;
  logic [7:0] rd_addr = 8'h00;
  logic [4:0] lag = 5'h03;
  logic [13:0] die_in = 14'h0000;
  logic [17:0] tp_in = 18'h00000;
  logic conv_start, die_valid, tp_valid;
  logic [13:0] die_sample;
  logic [17:0] tp_sample;
  logic [15:0] rd_data, tp_result, die_result, ed = 16'h0000, et = 16'h0000;
  logic [2:0] averaging_select;
  int error_cnt = 0, checked = 0, seed = 32'h3970CEB3;
  logic [2:0] sels [8] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2};

  // Clock
  always #50 clock = ~clock;

  tca_core #(.CONV_CYCLES(CONV), .STBY_CYCLES(STBY)) dut (.clock(clock), .reset(reset),
    .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .conv_start(conv_start), .die_valid(die_valid),
    .die_sample(die_sample), .tp_valid(tp_valid), .tp_sample(tp_sample), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .tp_result(tp_result), .die_result(die_result),
    .averaging_select(averaging_select));
  tca_conv_model u_conv (.clock(clock), .reset(reset), .conv_start(conv_start), .lag(lag),
    .die_in(die_in), .tp_in(tp_in), .die_valid(die_valid), .die_sample(die_sample),
    .tp_valid(tp_valid), .tp_sample(tp_sample));

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Inputs move 1 ns after the edge, outputs are read there too
  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // Caller drops rd_en, so back-to-back reads keep it high between them
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    rd_en = 1;
    rd_addr = a;
    step();
    chk(rd_data, exp, "read");
  endtask

  // Floor mean, then left-justify in 16 bits
  function automatic logic [15:0] exp_die(input logic signed [31:0] s, input int sh);
    logic signed [31:0] m;
    m = s >>> sh;
    return {m[13:0], 2'b00};
  endfunction

  // Floor mean, clipped to the 16-bit range
  function automatic logic [15:0] exp_tp(input logic signed [31:0] s, input int sh);
    logic signed [31:0] m;
    m = s >>> sh;
    if (m > $signed(32'h00007FFF)) return 16'h7FFF;
    if (m < $signed(32'hFFFF8000)) return 16'h8000;
    return m[15:0];
  endfunction

  // One whole averaging group; ext 1 or 2 drives full-scale samples
  task automatic group(input logic [2:0] sel, input int ext);
    int n, sh, k, last;
    logic signed [31:0] ds, ts;
    logic [2:0] x;
    sh = sel < 5 ? sel : sel - 5;
    last = (1 << sh) - 1;
    ds = 0;
    ts = 0;
    repeat ({$random(seed)} % 8) step();
    // Interim value differs from old and new, so both writes restart
    x = ~averaging_select;
    if (x == sel) x = x ^ 3'h1;
    cfg_wr = 1;
    cfg_sel = x;
    step();
    cfg_sel = sel;
    step();
    cfg_wr = 0;
    chk({13'h0000, averaging_select}, {13'h0000, sel}, "select");
    chk({15'h0000, conv_start}, 16'h0001, "restart");
    for (k = 0; k <= last; k++) begin
      lag = 5'({$random(seed)} % 17);
      die_in = ext == 1 ? 14'h1FFF : ext == 2 ? 14'h2000 : 14'($random(seed));
      tp_in = ext == 1 ? 18'h1FFFF : ext == 2 ? 18'h20000 : 18'($random(seed));
      ds += $signed(die_in);
      ts += $signed(tp_in);
      n = 0;
      do begin
        step();
        n++;
        if (k == last && n == CONV - 1) chk(die_result, ed, "early die");
        if (k == last && n == CONV - 1) chk(tp_result, et, "early tp");
        if (k == last && n == CONV) begin
          ed = exp_die(ds, sh);
          et = exp_tp(ts, sh);
          chk(die_result, ed, "die");
          chk(tp_result, et, "tp");
        end
      end while (conv_start !== 1'b1 && n < CONV + STBY + 5);
      if (k < last || sel < 5) chk(16'(n), 16'(CONV), "gap");
      else chk(16'(n >= CONV + STBY && n <= CONV + STBY + 1), 16'h0001, "standby");
    end
    rd(8'h00, et);
    rd(8'h01, ed);
    rd(8'h02, {13'h0000, sel});
    rd(8'h03 + 8'({$random(seed)} % 8'hF0), 16'h0000);
    rd_en = 0;
  endtask

  // Watchdog
  initial begin
    #(20000 * 100);
    error_cnt++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    #1;
    reset = 0;
    chk({13'h0000, averaging_select}, 16'h0002, "reset select");
    chk(tp_result | die_result, 16'h0000, "reset results");
    foreach (sels[i]) group(sels[i], 0);
    group(3'h0, 1);
    group(3'h5, 2);
    group(3'h1, 1);
    repeat (4) group(3'($random(seed)), 0);
    reset = 1;
    step();
    reset = 0;
    chk({13'h0000, averaging_select}, 16'h0002, "second reset");
    give_verdict();
  end
endmodule

// [dv/tca_conv_model.sv]
// Purpose: Converter model answering each conversion start
// Assumes: One die and one thermopile result per conversion
// Notes: Sample lines show junk outside their valid pulse
module tca_conv_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control
  input wire logic conv_start,
  input wire logic [4:0] lag,
  input wire logic [13:0] die_in,
  input wire logic [17:0] tp_in,
  // Results
  output logic die_valid,
  output logic [13:0] die_sample,
  output logic tp_valid,
  output logic [17:0] tp_sample
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Die first, thermopile next cycle; a start aborts the pending pair
  // Lag 16 puts the thermopile sample on the publish edge
  always @(posedge clock) begin
    cnt <= (reset || conv_start) ? 0 : cnt + 1;
    die_valid <= !reset && !conv_start && cnt == lag;
    tp_valid <= !reset && !conv_start && cnt == lag + 1;
    die_sample <= reset ? 14'h0000 : (cnt == lag) ? die_in : ~die_sample;
    tp_sample <= reset ? 18'h00000 : (cnt == lag + 1) ? tp_in : ~tp_sample;
  end
endmodule

// [inc/tca_pkg.sv]
// Purpose: Shared constants for the thermopile conversion averager
// Assumes: 10 MHz system clock, converter results arrive on the same clock
// Notes: Times are kept in their own unit; cycle counts derive from them
package tca_pkg;

  // Clock and conversion timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CONV_MS = 250;
  localparam int unsigned CONV_CYC = CONV_MS * (CLK_HZ / 1000);
  localparam int unsigned STBY_MS = 1000;
  localparam int unsigned STBY_CYC = STBY_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMER_W = 24;

  // Sample and result widths
  localparam int unsigned DIE_W = 14;
  localparam int unsigned TP_W = 18;
  localparam int unsigned ACC_GROW = 4;
  localparam int unsigned RES_W = 16;
  localparam int unsigned CNT_W = 5;

  // Averaging select field
  localparam logic [2:0] SEL_RESET = 3'h2;
  localparam logic [2:0] SEL_LP_FIRST = 3'h5;

  // Register indices on the read port
  localparam logic [7:0] ADDR_TP_RESULT = 8'h00;
  localparam logic [7:0] ADDR_DIE_RESULT = 8'h01;
  localparam logic [7:0] ADDR_AVG_SEL = 8'h02;

  // Saturation limits of the thermopile result
  localparam logic [15:0] TP_MAX = 16'h7FFF;
  localparam logic [15:0] TP_MIN = 16'h8000;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_STBY = 3'b100
  } tca_state_t;

endpackage

// [logic/tca_accum.sv]
// Purpose: Signed sample accumulator for one converter channel
// Assumes: Clear and add may coincide; the sample of that cycle is counted
// Notes: Total includes the current sample so a group can close on it
module tca_accum #(
  parameter int unsigned SW = 14,
  parameter int unsigned AW = 18
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic add,
  input wire logic [SW-1:0] sample,
  // Result
  output logic [AW-1:0] total
);

  logic [AW-1:0] sum_q;
  logic [AW-1:0] sum_d;
  logic [AW-1:0] ext;

  // Sign extend and add the sample of this cycle
  always_comb begin
    ext = {{(AW-SW){sample[SW-1]}}, sample};
    total = add ? AW'(sum_q + ext) : sum_q;
    sum_d = clear ? '0 : total;
  end

  // Register the running sum
  always_ff @(posedge clock) begin
    if (reset) begin
      sum_q <= '0;
    end else begin
      sum_q <= sum_d;
    end
  end

endmodule

// [logic/tca_core.sv]
// Purpose: Conversion sequencer and averager of a thermopile sensor
// Assumes: Converter strobes come from logic on this clock, no synchroniser
// Notes: Long counts are parameters so a simulation can shorten them
// Operation
// R01: Each cycle takes a die and thermopile sample
// R02: Select field sets number of averaged samples
// R03: Select field resets to four per second
// R04: Die result loads mean after Nth sample
// R05: Thermopile result loads mean after Nth sample
// R06: Low-power settings insert standby before next group
// R07: Thermopile result readable at address zero
// R08: Thermopile result saturates at 16-bit limits
// R09: Die result left-justified 14 bits, zeros below
// R10: Changing select restarts accumulation cleanly
module tca_core #(
  parameter int unsigned CONV_CYCLES = tca_pkg::CONV_CYC,
  parameter int unsigned STBY_CYCLES = tca_pkg::STBY_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Averaging configuration
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_sel,
  // Converter interface
  output logic conv_start,
  input wire logic die_valid,
  input wire logic [tca_pkg::DIE_W-1:0] die_sample,
  input wire logic tp_valid,
  input wire logic [tca_pkg::TP_W-1:0] tp_sample,
  // Register read port
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [15:0] rd_data,
  // Results
  output logic [15:0] tp_result,
  output logic [15:0] die_result,
  output logic [2:0] averaging_select
);

  localparam int unsigned DAW = tca_pkg::DIE_W + tca_pkg::ACC_GROW;
  localparam int unsigned TAW = tca_pkg::TP_W + tca_pkg::ACC_GROW;
  localparam logic [tca_pkg::TIMER_W-1:0] CONV_LAST = tca_pkg::TIMER_W'(CONV_CYCLES - 1);
  localparam logic [tca_pkg::TIMER_W-1:0] STBY_LAST = tca_pkg::TIMER_W'(STBY_CYCLES - 1);

  tca_pkg::tca_state_t state_q, state_d;
  logic [tca_pkg::TIMER_W-1:0] timer_q, timer_d;
  logic [tca_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] sel_q, sel_d;
  logic start_q, start_d;
  logic [15:0] tp_q, tp_d, die_q, die_d, rd_q, rd_d;
  logic low_power, sel_change, tick_end, pub, acc_clear, in_conv;
  logic [2:0] shift;
  logic [tca_pkg::CNT_W-1:0] n_m1;
  logic [DAW-1:0] die_total, die_mean;
  logic [TAW-1:0] tp_total, tp_mean;

  // Both channels accumulate only while converting
  assign in_conv = (state_q == tca_pkg::ST_CONV);
  assign acc_clear = pub | sel_change; // R10

  tca_accum #(.SW(tca_pkg::DIE_W), .AW(DAW)) u_die_acc (
    .clock(clock),
    .reset(reset),
    .clear(acc_clear),
    .add(die_valid & in_conv), // R01
    .sample(die_sample),
    .total(die_total)
  );

  tca_accum #(.SW(tca_pkg::TP_W), .AW(TAW)) u_tp_acc (
    .clock(clock),
    .reset(reset),
    .clear(acc_clear),
    .add(tp_valid & in_conv), // R01
    .sample(tp_sample),
    .total(tp_total)
  );

  // Decode the averaging count and group boundaries
  always_comb begin
    low_power = (sel_q >= tca_pkg::SEL_LP_FIRST); // R06
    shift = low_power ? 3'(sel_q - tca_pkg::SEL_LP_FIRST) : sel_q; // R02
    n_m1 = tca_pkg::CNT_W'((32'h1 << shift) - 32'h1); // R02
    sel_change = cfg_wr && (cfg_sel != sel_q); // R10
    tick_end = in_conv && (timer_q == CONV_LAST);
    pub = tick_end && (cnt_q == n_m1) && !sel_change; // R04 R05
    // Power of two count, so the mean is an arithmetic shift
    die_mean = DAW'($signed(die_total) >>> shift); // R04
    tp_mean = TAW'($signed(tp_total) >>> shift); // R05
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    cnt_d = cnt_q;
    start_d = 1'b0;
    case (state_q)
      tca_pkg::ST_IDLE: begin
        state_d = tca_pkg::ST_CONV;
        timer_d = '0;
        start_d = 1'b1;
      end
      tca_pkg::ST_CONV: begin
        if (tick_end) begin
          timer_d = '0;
          if (pub) begin
            cnt_d = '0;
            if (low_power) begin
              state_d = tca_pkg::ST_STBY; // R06
            end else begin
              start_d = 1'b1; // R01
            end
          end else begin
            cnt_d = tca_pkg::CNT_W'(cnt_q + 1'b1);
            start_d = 1'b1; // R01
          end
        end else begin
          timer_d = tca_pkg::TIMER_W'(timer_q + 1'b1);
        end
      end
      tca_pkg::ST_STBY: begin
        if (timer_q == STBY_LAST) begin
          state_d = tca_pkg::ST_CONV;
          timer_d = '0;
          start_d = 1'b1;
        end else begin
          timer_d = tca_pkg::TIMER_W'(timer_q + 1'b1);
        end
      end
      default: begin
        state_d = tca_pkg::ST_IDLE;
        timer_d = '0;
        cnt_d = '0;
      end
    endcase
    // A new setting discards the partial group and starts afresh
    if (sel_change) begin
      state_d = tca_pkg::ST_CONV; // R10
      timer_d = '0;
      cnt_d = '0;
      start_d = 1'b1;
    end
  end

  // Configuration, results and read data
  always_comb begin
    sel_d = cfg_wr ? cfg_sel : sel_q;
    tp_d = tp_q;
    die_d = die_q;
    if (pub) begin
      // Clip rather than wrap, so a hot object never reads as cold
      if ($signed(tp_mean) > $signed(TAW'($signed(tca_pkg::TP_MAX)))) begin
        tp_d = tca_pkg::TP_MAX; // R08
      end else if ($signed(tp_mean) < $signed({{(TAW-16){1'b1}}, tca_pkg::TP_MIN})) begin
        tp_d = tca_pkg::TP_MIN; // R08
      end else begin
        tp_d = tp_mean[15:0]; // R05
      end
      die_d = {die_mean[tca_pkg::DIE_W-1:0], 2'b00}; // R09
    end
    rd_d = rd_q;
    if (rd_en) begin
      case (rd_addr)
        tca_pkg::ADDR_TP_RESULT: rd_d = tp_q; // R07
        tca_pkg::ADDR_DIE_RESULT: rd_d = die_q;
        tca_pkg::ADDR_AVG_SEL: rd_d = {13'h0000, sel_q};
        default: rd_d = 16'h0000;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= tca_pkg::ST_IDLE;
      timer_q <= '0;
      cnt_q <= '0;
      start_q <= 1'b0;
      sel_q <= tca_pkg::SEL_RESET; // R03
      tp_q <= 16'h0000;
      die_q <= 16'h0000;
      rd_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      cnt_q <= cnt_d;
      start_q <= start_d;
      sel_q <= sel_d;
      tp_q <= tp_d;
      die_q <= die_d;
      rd_q <= rd_d;
    end
  end

  assign conv_start = start_q;
  assign rd_data = rd_q;
  assign tp_result = tp_q;
  assign die_result = die_q;
  assign averaging_select = sel_q;

  // Checks on the sequencer and result path
  AST_RST_SEL: assert property (@(posedge clock) reset |=> (sel_q == 3'h2)) // R03
    else $error("select not at four per second after reset");

  // Group size rebuilt from the select field, not from the decode above
  AST_PUB_COUNT: assert property (@(posedge clock) disable iff (reset)
    pub |-> tick_end && (cnt_q == ((sel_q >= 3'h5) ? (5'h01 << (sel_q - 3'h5)) : (5'h01 << sel_q)) - 5'h01)) // R02
    else $error("publish before the Nth sample");

  AST_DIE_HOLD: assert property (@(posedge clock) disable iff (reset)
    !pub |=> $stable(die_q)) // R04
    else $error("die result moved outside a group end");

  AST_TP_HOLD: assert property (@(posedge clock) disable iff (reset)
    !pub |=> $stable(tp_q)) // R05
    else $error("thermopile result moved outside a group end");

  AST_DIE_LSB: assert property (@(posedge clock) disable iff (reset)
    die_q[1:0] == 2'b00) // R09
    else $error("die result low bits not zero");

  AST_TP_SAT_HI: assert property (@(posedge clock) disable iff (reset)
    pub && ($signed(tp_mean) > $signed(TAW'(32767))) |=> (tp_q == 16'h7FFF)) // R08
    else $error("thermopile result did not clip high");

  AST_TP_SAT_LO: assert property (@(posedge clock) disable iff (reset)
    pub && ($signed(tp_mean) < -32'sd32768) |=> (tp_q == 16'h8000)) // R08
    else $error("thermopile result did not clip low");

  AST_RD_ZERO: assert property (@(posedge clock) disable iff (reset)
    rd_en && (rd_addr == 8'h00) |=> (rd_q == $past(tp_q))) // R07
    else $error("address zero does not return thermopile result");

  AST_RESTART: assert property (@(posedge clock) disable iff (reset)
    sel_change |=> (cnt_q == 5'h00) && (timer_q == 24'h000000) && in_conv && start_q) // R10
    else $error("setting change did not restart the group");

  AST_STBY: assert property (@(posedge clock) disable iff (reset)
    pub && low_power |=> (state_q == tca_pkg::ST_STBY) && !start_q) // R06
    else $error("low-power setting skipped standby");

  AST_START: assert property (@(posedge clock) disable iff (reset)
    start_q |-> in_conv && (timer_q == 24'h000000) ##1 (!start_q || $past(sel_change))) // R01
    else $error("conversion start not a single pulse at cycle start");

endmodule
